/* File: rtl/sqsc_top.v */
// Global switch QoS, snooping and mirroring control registers,
// with the per-frame decisions the forwarding engine takes from them.
// Assumes frame attributes are presented with pkt_valid_i, synchronous to clk_i.
// Operation
// - DSCP 0x3F takes the upper 3-bit field, 0x3E the lower, both reset to zero.
// - With IGMP snooping enabled every IGMP packet goes to the host port.
// - With MLD snooping enabled every MLD packet goes to the host port.
// - With the option bit set, next headers 43,44,50,51,60 (direct or hop-by-hop) are MLD.
// - With the option bit clear, next headers 1 or 58 (direct or hop-by-hop) are MLD.
// - Sniff mode one mirrors only when source and destination both match.
// - Sniff mode zero mirrors when source or destination matches.
// - WRED map holds red, yellow, green 2-bit values resetting to 3, 2, 1.
// - Event override forces PTP event frames to a 4-bit priority resetting to 15.
// - Non-event override forces PTP non-event frames to their 4-bit priority.
// - In two-queue mode the 2-bit priority maps to low or high by the split field.
// - Split 00 puts only 3 high, 10 puts 2 and 3 high, 11 puts all but 0 high.
// - Membership discard set limits every frame to its membership ports.
// - Membership discard clear leaves single-destination frames unlimited.
// - Discard clear with mirroring drops a single-destination frame mirrored elsewhere.
`timescale 1ns/1ns
`include "sqsc_defs.vh"
module sqsc_top (
   input wire clk_i,
   input wire nrst_i,
   input wire [`SQSC_AW-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`SQSC_AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire pkt_valid_i,
   input wire [5:0] dscp_i,
   input wire is_igmp_i,
   input wire is_ipv6_i,
   input wire [7:0] next_hdr_i,
   input wire [7:0] hop_hdr_i,
   input wire src_match_i,
   input wire dst_match_i,
   input wire ptp_event_i,
   input wire ptp_nonevent_i,
   input wire [3:0] qos_prio_i,
   input wire two_queue_i,
   input wire [1:0] regen_prio_i,
   input wire single_dest_i,
   input wire [`SQSC_PORTS-1:0] fwd_ports_i,
   input wire [`SQSC_PORTS-1:0] member_ports_i,
   input wire mirror_en_i,
   input wire mirror_other_i,
   output reg res_valid_o,
   output reg dscp_hit_o,
   output reg [2:0] dscp_prio_o,
   output reg to_host_o,
   output reg mirror_o,
   output reg [3:0] queue_prio_o,
   output reg high_queue_o,
   output reg [`SQSC_PORTS-1:0] fwd_ports_o,
   output reg drop_o,
   output wire [1:0] wred_red_o,
   output wire [1:0] wred_yellow_o,
   output wire [1:0] wred_green_o
);
   reg [7:0] dscp_top_priority_map;
   reg [7:0] mirror_snoop_global_ctrl;
   reg [7:0] wred_color_dscp_map;
   reg [7:0] ptp_event_priority_ctrl;
   reg [7:0] ptp_nonevent_priority_ctrl;
   reg [7:0] queue_management_ctrl;

   reg aw_full;
   reg w_full;
   reg [11:0] aw_idx;
   reg [7:0] w_byte;
   reg w_lane0;
   reg [7:0] next_rdata;
   reg rd_hit;
   wire [11:0] ar_idx;
   wire do_write;
   wire wr_hit;

   // Per-register load strobes
   wire wr_lane0;
   wire we_dscp;
   wire we_mirr;
   wire we_wred;
   wire we_ptpe;
   wire we_ptpn;
   wire we_qmgt;

   assign s_axi_awready = ~aw_full;
   assign s_axi_wready = ~w_full;
   // One read in flight; address is refused while the answer waits
   assign s_axi_arready = ~s_axi_rvalid;
   assign ar_idx = s_axi_araddr[`SQSC_AW-1:2];
   // Write fires once both halves are held and the last response is gone
   assign do_write = aw_full & w_full & ~s_axi_bvalid;
   // A write with byte lane 0 off still answers OKAY but changes nothing
   assign wr_lane0 = do_write & w_lane0;
   // One strobe per register keeps each register's reset and load side by side
   assign we_dscp = wr_lane0 & (aw_idx == `SQSC_IDX_DSCP);
   assign we_mirr = wr_lane0 & (aw_idx == `SQSC_IDX_MIRR);
   assign we_wred = wr_lane0 & (aw_idx == `SQSC_IDX_WRED);
   assign we_ptpe = wr_lane0 & (aw_idx == `SQSC_IDX_PTPE);
   assign we_ptpn = wr_lane0 & (aw_idx == `SQSC_IDX_PTPN);
   assign we_qmgt = wr_lane0 & (aw_idx == `SQSC_IDX_QMGT);
   assign wr_hit = (aw_idx == `SQSC_IDX_DSCP) | (aw_idx == `SQSC_IDX_MIRR) |
                   (aw_idx == `SQSC_IDX_WRED) | (aw_idx == `SQSC_IDX_PTPE) |
                   (aw_idx == `SQSC_IDX_PTPN) | (aw_idx == `SQSC_IDX_QMGT);

   // Address half is held until the write fires, so awready stays low meanwhile
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_full <= 1'b0;
         aw_idx <= 12'h000;
      end else if (do_write) begin
         aw_full <= 1'b0;
      end else if (s_axi_awvalid && !aw_full) begin
         aw_full <= 1'b1;
         aw_idx <= s_axi_awaddr[`SQSC_AW-1:2];
      end
   end

   // Data half arrives independently of the address half
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         w_full <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (do_write) begin
         w_full <= 1'b0;
      end else if (s_axi_wvalid && !w_full) begin
         w_full <= 1'b1;
         w_byte <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end
   end

   // A new response is only raised once the previous one has been taken
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SQSC_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `SQSC_OKAY : `SQSC_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only byte lane 0 holds implemented bits; upper lanes are read-only zero
   // both fields reset to zero
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dscp_top_priority_map <= `SQSC_RST_DSCP;
      end else if (we_dscp) begin
         dscp_top_priority_map <= w_byte & `SQSC_WM_DSCP;
      end
   end

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mirror_snoop_global_ctrl <= `SQSC_RST_MIRR;
      end else if (we_mirr) begin
         mirror_snoop_global_ctrl <= w_byte & `SQSC_WM_MIRR;
      end
   end

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wred_color_dscp_map <= `SQSC_RST_WRED;
      end else if (we_wred) begin
         wred_color_dscp_map <= w_byte & `SQSC_WM_WRED;
      end
   end

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ptp_event_priority_ctrl <= `SQSC_RST_PTPE;
      end else if (we_ptpe) begin
         ptp_event_priority_ctrl <= w_byte & `SQSC_WM_PTP;
      end
   end

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ptp_nonevent_priority_ctrl <= `SQSC_RST_PTPN;
      end else if (we_ptpn) begin
         ptp_nonevent_priority_ctrl <= w_byte & `SQSC_WM_PTP;
      end
   end

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         queue_management_ctrl <= `SQSC_RST_QMGT;
      end else if (we_qmgt) begin
         queue_management_ctrl <= w_byte & `SQSC_WM_QMGT;
      end
   end

   // Unmapped reads answer zero with SLVERR
   always @* begin
      next_rdata = 8'h00;
      rd_hit = 1'b1;
      case (ar_idx)
         `SQSC_IDX_DSCP: next_rdata = dscp_top_priority_map;
         `SQSC_IDX_MIRR: next_rdata = mirror_snoop_global_ctrl;
         `SQSC_IDX_WRED: next_rdata = wred_color_dscp_map;
         `SQSC_IDX_PTPE: next_rdata = ptp_event_priority_ctrl;
         `SQSC_IDX_PTPN: next_rdata = ptp_nonevent_priority_ctrl;
         `SQSC_IDX_QMGT: next_rdata = queue_management_ctrl;
         default: rd_hit = 1'b0;
      endcase
   end

   // Read data is captured with the address, so it cannot move while rvalid waits
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SQSC_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, next_rdata};
         s_axi_rresp <= rd_hit ? `SQSC_OKAY : `SQSC_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // colour values straight from the map
   assign wred_red_o = wred_color_dscp_map[5:4];
   assign wred_yellow_o = wred_color_dscp_map[3:2];
   assign wred_green_o = wred_color_dscp_map[1:0];

   wire is_mld;
   wire split_high;
   reg next_dscp_hit;
   reg [2:0] next_dscp_prio;
   reg next_to_host;
   reg next_mirror;
   reg [3:0] next_queue_prio;
   reg next_drop;
   wire [`SQSC_PORTS-1:0] next_fwd;
   wire memb_discard;
   wire limit_all;

   sqsc_mld_detect u_mld (
      .opt_i(mirror_snoop_global_ctrl[`SQSC_B_MLDOPT]),
      .next_hdr_i(next_hdr_i),
      .hop_hdr_i(hop_hdr_i),
      .is_mld_o(is_mld)
   );

   sqsc_queue_map u_qmap (
      .split_i(queue_management_ctrl[7:6]),
      .prio_i(regen_prio_i),
      .high_o(split_high)
   );

   always @* begin
      next_dscp_hit = (dscp_i == `SQSC_DSCP_UP) || (dscp_i == `SQSC_DSCP_LO);
      if (dscp_i == `SQSC_DSCP_UP) begin
         next_dscp_prio = dscp_top_priority_map[6:4];
      end else begin
         next_dscp_prio = dscp_top_priority_map[2:0];
      end
      next_to_host = (is_igmp_i & mirror_snoop_global_ctrl[`SQSC_B_IGMP]) |
                     (is_ipv6_i & is_mld & mirror_snoop_global_ctrl[`SQSC_B_MLDEN]);
      if (mirror_snoop_global_ctrl[`SQSC_B_SNIFF]) begin
         next_mirror = src_match_i & dst_match_i;
      end else begin
         next_mirror = src_match_i | dst_match_i;
      end
      if (ptp_event_i && ptp_event_priority_ctrl[`SQSC_B_PTPOVR]) begin
         next_queue_prio = ptp_event_priority_ctrl[3:0];
      end else if (ptp_nonevent_i && ptp_nonevent_priority_ctrl[`SQSC_B_PTPOVR]) begin
         next_queue_prio = ptp_nonevent_priority_ctrl[3:0];
      end else begin
         next_queue_prio = qos_prio_i;
      end
      next_drop = ~memb_discard & mirror_en_i & single_dest_i & mirror_other_i;
   end

   assign memb_discard = queue_management_ctrl[`SQSC_B_MEMB];
   assign limit_all = memb_discard | ~single_dest_i;

   genvar gp;
   generate
      for (gp = 0; gp < `SQSC_PORTS; gp = gp + 1) begin : g_port
         assign next_fwd[gp] = fwd_ports_i[gp] & (member_ports_i[gp] | ~limit_all);
      end
   endgenerate

   // Decisions are registered so the engine sees them one cycle after the frame
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         res_valid_o <= 1'b0;
         dscp_hit_o <= 1'b0;
         dscp_prio_o <= 3'h0;
         to_host_o <= 1'b0;
         mirror_o <= 1'b0;
         queue_prio_o <= 4'h0;
         high_queue_o <= 1'b0;
         fwd_ports_o <= {`SQSC_PORTS{1'b0}};
         drop_o <= 1'b0;
      end else begin
         res_valid_o <= pkt_valid_i;
         if (pkt_valid_i) begin
            dscp_hit_o <= next_dscp_hit;
            dscp_prio_o <= next_dscp_prio;
            to_host_o <= next_to_host;
            mirror_o <= next_mirror;
            queue_prio_o <= next_queue_prio;
            // high queue only in two-queue mode
            high_queue_o <= two_queue_i & split_high;
            fwd_ports_o <= next_fwd;
            drop_o <= next_drop;
         end
      end
   end
endmodule // sqsc_top

/* File: rtl/sqsc_defs.vh */
// Constants for the switch QoS and snoop control block.
// Assumes byte addressing on a 32-bit AXI4-Lite bus, one word per register.
`ifndef SQSC_DEFS_VH
`define SQSC_DEFS_VH
`define SQSC_AW 14
// Register indices; byte address is four times the index
`define SQSC_IDX_DSCP 12'h35f
`define SQSC_IDX_MIRR 12'h370
`define SQSC_IDX_WRED 12'h378
`define SQSC_IDX_PTPE 12'h37c
`define SQSC_IDX_PTPN 12'h37d
`define SQSC_IDX_QMGT 12'h390
// Reset values
`define SQSC_RST_DSCP 8'h00
`define SQSC_RST_MIRR 8'h00
`define SQSC_RST_WRED 8'h39
`define SQSC_RST_PTPE 8'h0f
`define SQSC_RST_PTPN 8'h0f
`define SQSC_RST_QMGT 8'h82
// Writable bit masks; other bits read zero
`define SQSC_WM_DSCP 8'h77
`define SQSC_WM_MIRR 8'h4d
`define SQSC_WM_WRED 8'h3f
`define SQSC_WM_PTP 8'h8f
`define SQSC_WM_QMGT 8'hff
// Field positions
`define SQSC_B_IGMP 6
`define SQSC_B_MLDOPT 3
`define SQSC_B_MLDEN 2
`define SQSC_B_SNIFF 0
`define SQSC_B_PTPOVR 7
`define SQSC_B_MEMB 1
// DSCP code points with their own priority fields
`define SQSC_DSCP_UP 6'h3f
`define SQSC_DSCP_LO 6'h3e
// IPv6 next header values
`define SQSC_NH_HOP 8'h00
`define SQSC_NH_ICMP 8'h01
`define SQSC_NH_MLD 8'h3a
`define SQSC_NH_ROUTE 8'h2b
`define SQSC_NH_FRAG 8'h2c
`define SQSC_NH_ESP 8'h32
`define SQSC_NH_AUTH 8'h33
`define SQSC_NH_DEST 8'h3c
// Two-queue split encodings
`define SQSC_SPL_3HI 2'h0
`define SQSC_SPL_2HI 2'h2
`define SQSC_SPL_1HI 2'h3
`define SQSC_PORTS 3
`define SQSC_OKAY 2'h0
`define SQSC_SLVERR 2'h2
`endif

/* File: rtl/sqsc_mld_detect.v */
// IPv6 next header classifier for MLD snooping.
// Assumes next header fields arrive already extracted from the frame.
`timescale 1ns/1ns
`include "sqsc_defs.vh"
module sqsc_mld_detect (
   input wire opt_i,
   input wire [7:0] next_hdr_i,
   input wire [7:0] hop_hdr_i,
   output reg is_mld_o
);
   function hit;
      input o;
      input [7:0] nh;
      begin
         if (o) begin
            hit = (nh == `SQSC_NH_ROUTE) || (nh == `SQSC_NH_FRAG) ||
                  (nh == `SQSC_NH_ESP) || (nh == `SQSC_NH_AUTH) ||
                  (nh == `SQSC_NH_DEST);
         end else begin
            hit = (nh == `SQSC_NH_ICMP) || (nh == `SQSC_NH_MLD);
         end
      end
   endfunction
   always @* begin
      is_mld_o = hit(opt_i, next_hdr_i) ||
                 ((next_hdr_i == `SQSC_NH_HOP) && hit(opt_i, hop_hdr_i));
   end
endmodule // sqsc_mld_detect

/* File: rtl/sqsc_queue_map.v */
// Two-queue split of a 2-bit regenerated priority.
// Assumes the caller only uses the result in two-queue configuration.
`timescale 1ns/1ns
`include "sqsc_defs.vh"
module sqsc_queue_map (
   input wire [1:0] split_i,
   input wire [1:0] prio_i,
   output reg high_o
);
   always @* begin
      case (split_i)
         `SQSC_SPL_3HI: high_o = (prio_i == 2'h3);
         `SQSC_SPL_2HI: high_o = (prio_i >= 2'h2);
         `SQSC_SPL_1HI: high_o = (prio_i != 2'h0);
         // Unused code behaves as the reset split
         default: high_o = (prio_i >= 2'h2);
      endcase
   end
endmodule // sqsc_queue_map

/* File: verif/sqsc_properties.sv */
// Checker for the switch QoS control block: per-frame decisions.
// Assumes it is bound to sqsc_top and sees only that module's ports.
`timescale 1ns/1ns
`include "sqsc_defs.vh"
module sqsc_properties (
   input wire clk_i,
   input wire nrst_i,
   input wire pkt_valid_i,
   input wire is_igmp_i,
   input wire is_ipv6_i,
   input wire src_match_i,
   input wire dst_match_i,
   input wire two_queue_i,
   input wire [1:0] regen_prio_i,
   input wire single_dest_i,
   input wire [`SQSC_PORTS-1:0] fwd_ports_i,
   input wire mirror_en_i,
   input wire mirror_other_i,
   input wire res_valid_o,
   input wire to_host_o,
   input wire mirror_o,
   input wire high_queue_o,
   input wire [`SQSC_PORTS-1:0] fwd_ports_o,
   input wire drop_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_frame;
      pkt_valid_i;
   endsequence
   sequence s_result;
      res_valid_o ##1 !res_valid_o;
   endsequence
   sequence s_no_match;
      pkt_valid_i && !src_match_i && !dst_match_i;
   endsequence
   sequence s_top_prio;
      pkt_valid_i && two_queue_i && regen_prio_i == 2'h3;
   endsequence
   sequence s_no_drop_cause;
      pkt_valid_i && !(single_dest_i && mirror_en_i && mirror_other_i);
   endsequence
   // A lone frame gives exactly one result pulse
   a_frame_result: assert property (s_frame ##1 !pkt_valid_i |-> s_result)
      else $error("frame result pulse wrong");
   a_result_cause: assert property (!pkt_valid_i |=> !res_valid_o)
      else $error("result without frame");
   a_host_cause: assert property (pkt_valid_i && !is_igmp_i && !is_ipv6_i |=> !to_host_o)
      else $error("host copy without cause");
   a_mirror_none: assert property (s_no_match |=> !mirror_o)
      else $error("mirror without match");
   a_mirror_both: assert property (pkt_valid_i && src_match_i && dst_match_i |=> mirror_o)
      else $error("mirror missed on full match");
   a_one_queue: assert property (pkt_valid_i && !two_queue_i |=> !high_queue_o)
      else $error("high queue outside two-queue mode");
   a_top_prio: assert property (s_top_prio |=> high_queue_o)
      else $error("priority 3 not high");
   a_fwd_subset: assert property (pkt_valid_i |=> !(fwd_ports_o & ~$past(fwd_ports_i)))
      else $error("forward port added");
   a_drop_cause: assert property (s_no_drop_cause |=> !drop_o)
      else $error("drop without cause");
endmodule // sqsc_properties

/* File: verif/sqsc_top_test.sv */
// Self-checking bench for the switch QoS, snooping and mirroring controls.
// Assumes sqsc_defs.vh on the include path; bready and rready stay high throughout.
`timescale 1ns/1ns
`include "sqsc_defs.vh"
module sqsc_top_test;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pkt_valid_i, is_igmp_i;
   logic is_ipv6_i, src_match_i, dst_match_i, ptp_event_i, ptp_nonevent_i, two_queue_i;
   logic single_dest_i, mirror_en_i, mirror_other_i, res_valid_o, dscp_hit_o, to_host_o;
   logic mirror_o, high_queue_o, drop_o;
   logic [1:0] s_axi_bresp, s_axi_rresp, regen_prio_i, wred_red_o, wred_yellow_o, wred_green_o;
   logic [2:0] dscp_prio_o, fwd_ports_i, member_ports_i, fwd_ports_o;
   logic [3:0] s_axi_wstrb, qos_prio_i, queue_prio_o;
   logic [5:0] dscp_i;
   logic [7:0] next_hdr_i, hop_hdr_i;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   int mismatches = 0;
   int total_checks = 0;
   // Byte address is four times the register index
   logic [13:0] adr [6] = '{{`SQSC_IDX_DSCP, 2'h0}, {`SQSC_IDX_MIRR, 2'h0}, {`SQSC_IDX_WRED, 2'h0},
      {`SQSC_IDX_PTPE, 2'h0}, {`SQSC_IDX_PTPN, 2'h0}, {`SQSC_IDX_QMGT, 2'h0}};
   logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'h39, 8'h0f, 8'h0f, 8'h82};
   logic [7:0] msk_v [6] = '{8'h77, 8'h4d, 8'h3f, 8'h8f, 8'h8f, 8'hff};
   logic [7:0] opt_nh [5] = '{8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c};
   sqsc_top dut (.*);
   always #10 clk_i = ~clk_i;
   task ck(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      fork
         begin
            do @(posedge clk_i); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge clk_i); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge clk_i); while (!s_axi_bvalid);
      ck("bresp", r, s_axi_bresp);
   endtask
   task rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_i); while (!s_axi_rvalid);
      ck("rdata", e, s_axi_rdata);
      ck("rresp", r, s_axi_rresp);
   endtask
   // Result is read at the edge ending its one-cycle pulse, before it clears
   task fr;
      pkt_valid_i <= 1'b1;
      @(posedge clk_i);
      pkt_valid_i <= 1'b0;
      @(posedge clk_i);
      ck("res_valid", 1'h1, res_valid_o);
   endtask
   task dsc(input logic [5:0] d, input logic h, input logic [2:0] p);
      dscp_i <= d;
      fr;
      ck("dscp_hit", h, dscp_hit_o);
      if (h)
         ck("dscp_prio", p, dscp_prio_o);
   endtask
   task snp(input logic ig, v6, input logic [7:0] nh, hp, input logic e);
      {is_igmp_i, is_ipv6_i, next_hdr_i, hop_hdr_i} <= {ig, v6, nh, hp};
      fr;
      ck("to_host", e, to_host_o);
   endtask
   task mir(input logic s, d, e);
      {src_match_i, dst_match_i} <= {s, d};
      fr;
      ck("mirror", e, mirror_o);
   endtask
   task pq(input logic ev, ne, input logic [3:0] e);
      {ptp_event_i, ptp_nonevent_i} <= {ev, ne};
      fr;
      ck("queue_prio", e, queue_prio_o);
   endtask
   task hq(input logic tq, input logic [1:0] p, input logic e);
      {two_queue_i, regen_prio_i} <= {tq, p};
      fr;
      ck("high_queue", e, high_queue_o);
   endtask
   task fw(input logic sd, me, mo, input logic [2:0] e, input logic dr);
      {single_dest_i, mirror_en_i, mirror_other_i} <= {sd, me, mo};
      fr;
      ck("fwd_ports", e, fwd_ports_o);
      ck("drop", dr, drop_o);
   endtask
   task end_sim;
      if (mismatches == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, pkt_valid_i, is_igmp_i, is_ipv6_i} = '0;
      {src_match_i, dst_match_i, ptp_event_i, ptp_nonevent_i, two_queue_i, single_dest_i} = '0;
      {mirror_en_i, mirror_other_i, regen_prio_i, dscp_i, next_hdr_i, hop_hdr_i} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb, qos_prio_i} = 10'h3f3;
      {fwd_ports_i, member_ports_i} = 6'h3a;
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      ck("wred_red", 2'h3, wred_red_o);
      ck("wred_yellow", 2'h2, wred_yellow_o);
      ck("wred_green", 2'h1, wred_green_o);
      for (int i = 0; i < 6; i++) begin
         rd(adr[i], rst_v[i], 2'h0);
         wr(adr[i], 32'hffffffff, 2'h0);
         rd(adr[i], msk_v[i], 2'h0);
      end
      ck("wred_green", 2'h3, wred_green_o);
      wr(14'h0004, 32'h0, 2'h2);
      rd(14'h0004, 32'h0, 2'h2);
      // Lane 0 strobe off: answered OKAY, register untouched
      s_axi_wstrb <= 4'he;
      wr(adr[2], 32'h0, 2'h0);
      s_axi_wstrb <= 4'hf;
      rd(adr[2], 32'h3f, 2'h0);
      wr(adr[0], 32'h53, 2'h0);
      dsc(6'h3f, 1'h1, 3'h5);
      dsc(6'h3e, 1'h1, 3'h3);
      dsc(6'h3d, 1'h0, 3'h0);
      wr(adr[1], 32'h44, 2'h0);
      snp(1'h1, 1'h0, 8'h00, 8'h00, 1'h1);
      snp(1'h0, 1'h1, 8'h3a, 8'h00, 1'h1);
      snp(1'h0, 1'h1, 8'h00, 8'h01, 1'h1);
      snp(1'h0, 1'h1, 8'h2b, 8'h00, 1'h0);
      wr(adr[1], 32'h4c, 2'h0);
      for (int i = 0; i < 5; i++) begin
         snp(1'h0, 1'h1, opt_nh[i], 8'h00, 1'h1);
         snp(1'h0, 1'h1, 8'h00, opt_nh[i], 1'h1);
      end
      snp(1'h0, 1'h1, 8'h3a, 8'h00, 1'h0);
      wr(adr[1], 32'h08, 2'h0);
      snp(1'h1, 1'h0, 8'h00, 8'h00, 1'h0);
      snp(1'h0, 1'h1, 8'h2b, 8'h00, 1'h0);
      mir(1'h1, 1'h0, 1'h1);
      mir(1'h0, 1'h1, 1'h1);
      mir(1'h0, 1'h0, 1'h0);
      wr(adr[1], 32'h01, 2'h0);
      mir(1'h1, 1'h0, 1'h0);
      mir(1'h1, 1'h1, 1'h1);
      wr(adr[3], 32'h85, 2'h0);
      wr(adr[4], 32'h8a, 2'h0);
      pq(1'h1, 1'h0, 4'h5);
      pq(1'h0, 1'h1, 4'ha);
      pq(1'h0, 1'h0, 4'h3);
      wr(adr[3], 32'h05, 2'h0);
      wr(adr[4], 32'h0a, 2'h0);
      pq(1'h1, 1'h0, 4'h3);
      pq(1'h0, 1'h1, 4'h3);
      // Unused split code 01 is expected to act as the reset split 10
      for (int s = 0; s < 4; s++) begin
         wr(adr[5], {24'h0, 2'(s), 6'h02}, 2'h0);
         for (int p = 0; p < 4; p++) begin
            hq(1'h1, 2'(p), (s == 0) ? p == 3 : (s == 3) ? p >= 1 : p >= 2);
         end
      end
      hq(1'h0, 2'h3, 1'h0);
      fw(1'h1, 1'h1, 1'h1, 3'h2, 1'h0);
      wr(adr[5], 32'h80, 2'h0);
      fw(1'h1, 1'h0, 1'h0, 3'h7, 1'h0);
      fw(1'h0, 1'h0, 1'h0, 3'h2, 1'h0);
      fw(1'h1, 1'h1, 1'h1, 3'h7, 1'h1);
      fw(1'h1, 1'h1, 1'h0, 3'h7, 1'h0);
      end_sim;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      end_sim;
   end
endmodule // sqsc_top_test
bind sqsc_top sqsc_properties chk (.*);
